// File: dv/bstsh_ctl_model.sv
`timescale 1ns/1ps
// Sequencing control: counts stalled cycles and steps its address when allowed.
module bstsh_ctl_model (
   input  wire       aclk,
   input  wire       aresetn,
   input  wire       block_microword_load,
   input  wire       sequencer_address_clock_enable,
   output reg  [7:0] stall_count_reg,
   output reg  [7:0] seq_addr_reg
);
   // The next microword is held back while the unit blocks it.
   always @(posedge aclk) begin
      if (!aresetn) begin
         stall_count_reg <= 8'h00;
         seq_addr_reg    <= 8'h00;
      end else begin
         if (block_microword_load) stall_count_reg <= stall_count_reg + 8'h01;
         if (sequencer_address_clock_enable) seq_addr_reg <= seq_addr_reg + 8'h01;
      end
   end
endmodule // bstsh_ctl_model

// File: dv/bstsh_unit_assertions.sv
`timescale 1ns/1ps
// Watches the register bus handshakes and the shift stall outputs of the unit.
module bstsh_unit_chk (
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_awready,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        block_microword_load,
   input wire        sequencer_address_clock_enable
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////
   stall_pair_a: assert property (block_microword_load == !sequencer_address_clock_enable)
      else $error("Stall outputs disagree.");
   stall_once_a: assert property ($rose(block_microword_load) |=> !block_microword_load)
      else $error("Microword block lasted more than one cycle.");
   resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("Write response dropped early.");
   resp_clear_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("Write response held after handshake.");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("Read data dropped early.");
   read_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("Upper read bits not zero.");
   read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("Read answer late.");
   ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
      else $error("Read address ready wrong.");
   write_gate_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("Write accepted during response.");
endmodule // bstsh_unit_chk

// File: dv/tb_bstsh_unit.sv
`timescale 1ns/1ps
`include "bstsh_defs.vh"
module tb_bstsh_unit;
   reg         aclk = 1'b0, aresetn = 1'b0;
   reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   reg  [31:0] s_axi_wdata = 32'h0;
   reg  [3:0]  s_axi_wstrb = 4'hf;
   reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire        block_microword_load, sequencer_address_clock_enable;
   wire [7:0]  stalls;
   integer     bad_count = 0, checks_done = 0;
   reg  [31:0] rd_val;
   reg  [1:0]  rsp;
   // Clock of 100 MHz.
   always #5 aclk = ~aclk;
   bstsh_unit #(.AW(8)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .block_microword_load, .sequencer_address_clock_enable);
   bstsh_ctl_model ctl (.aclk, .aresetn, .block_microword_load, .sequencer_address_clock_enable,
      .stall_count_reg(stalls), .seq_addr_reg());
   ////////////////////////////////////////////////////////////////////////
   // Prints the counts and the verdict, then stops.
   task final_report;
      begin
         $display("Checks %0d, mismatches %0d", checks_done, bad_count);
         if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
         end
      end
   endtask
   task fail;
      begin
         bad_count = bad_count + 1;
         $display("Error at %0t ns: bus wait expired", $time);
         final_report;
      end
   endtask
   // Bus write: address and data offered together, each released when taken.
   task wr(input [7:0] a, input [31:0] d);
      integer i;
      reg     got, aw_ok, w_ok;
      begin
         got = 1'b0;
         @(posedge aclk);
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         // Handshakes are judged on settled values half a cycle before the edge.
         for (i = 0; i < 50 && !got; i = i + 1) begin
            @(negedge aclk);
            aw_ok = s_axi_awvalid && s_axi_awready;
            w_ok = s_axi_wvalid && s_axi_wready;
            got = s_axi_bvalid;
            if (got) rsp = s_axi_bresp;
            @(posedge aclk);
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
            if (got) s_axi_bready <= 1'b0;
         end
         if (!got) fail;
      end
   endtask
   task rd(input [7:0] a);
      integer i;
      reg     got, ar_ok;
      begin
         got = 1'b0;
         @(posedge aclk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         for (i = 0; i < 50 && !got; i = i + 1) begin
            @(negedge aclk);
            ar_ok = s_axi_arvalid && s_axi_arready;
            got = s_axi_rvalid;
            if (got) rd_val = s_axi_rdata;
            if (got) rsp = s_axi_rresp;
            @(posedge aclk);
            if (ar_ok) s_axi_arvalid <= 1'b0;
            if (got) s_axi_rready <= 1'b0;
         end
         if (!got) fail;
      end
   endtask
   // Loads A and B, issues a command, waits for idle and compares A and B.
   task run(input [15:0] a, input [15:0] b, input [31:0] cmd, input [15:0] ea, input [15:0] eb);
      integer i;
      begin
         wr(`BSTSH_A_OFS, {16'h0, a});
         wr(`BSTSH_B_OFS, {16'h0, b});
         wr(`BSTSH_CMD_OFS, cmd);
         rd_val = 32'h1;
         for (i = 0; i < 20 && rd_val[0] !== 1'b0; i = i + 1) rd(`BSTSH_STAT_OFS);
         if (rd_val[0] !== 1'b0) fail;
         rd(`BSTSH_A_OFS);
         chk(rd_val, {16'h0, ea});
         rd(`BSTSH_B_OFS);
         chk(rd_val, {16'h0, eb});
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence: sense, toggle and shift cases, then an unmapped read.
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`BSTSH_B_OFS);
      chk(rd_val, 32'h0);
      run(16'hf7ff, 16'h0005, 32'h001, 16'hf7ff, 16'h0009);
      rd(`BSTSH_STAT_OFS);
      chk(rd_val, 32'h44);
      run(16'h0010, 16'h0000, 32'h009, 16'h0010, 16'h000b);
      run(16'h0800, 16'h0001, 32'h00a, 16'h0000, 16'h0005);
      run(16'h7fff, 16'h0003, 32'h002, 16'hffff, 16'h0003);
      run(16'hfffe, 16'h0000, 32'h002, 16'hffff, 16'h000f);
      run(16'hffff, 16'h0002, 32'h002, 16'hffff, 16'h0012);
      rd(`BSTSH_STAT_OFS);
      chk(rd_val & 32'h4, 32'h0);
      run(16'h0000, 16'h1234, 32'h043, 16'h0001, 16'h2340);
      run(16'h8001, 16'h8000, 32'h013, 16'h0003, 16'h0000);
      run(16'h0000, 16'h0001, 32'h0f3, 16'h0000, 16'h8000);
      run(16'h0000, 16'h1234, 32'h044, 16'h0123, 16'h4000);
      run(16'h0000, 16'h1234, 32'h004, 16'h1234, 16'h0000);
      wr(`BSTSH_D_OFS, 32'h3);
      run(16'h0000, 16'h00ff, 32'h005, 16'h0000, 16'h07f8);
      wr(`BSTSH_MI_OFS, 32'h20);
      run(16'h0000, 16'h1234, 32'h106, 16'h048d, 16'h0000);
      chk({24'h0, stalls}, 32'h7);
      rd(8'h18);
      chk({30'h0, rsp}, 32'h2);
      chk(rd_val, 32'h0);
      final_report;
   end
endmodule // tb_bstsh_unit
bind bstsh_unit bstsh_unit_chk u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .block_microword_load, .sequencer_address_clock_enable);

// File: hw/bstsh_defs.vh
`ifndef BSTSH_DEFS_VH
`define BSTSH_DEFS_VH

// Register byte offsets on the AXI4-Lite bus.
`define BSTSH_A_OFS        8'h00
`define BSTSH_B_OFS        8'h04
`define BSTSH_D_OFS        8'h08
`define BSTSH_MI_OFS       8'h0c
`define BSTSH_CMD_OFS      8'h10
`define BSTSH_STAT_OFS     8'h14

// Command register field positions.
`define BSTSH_CMD_OP_LSB   0
`define BSTSH_CMD_OP_MSB   2
`define BSTSH_CMD_POL_BIT  3
`define BSTSH_CMD_X_LSB    4
`define BSTSH_CMD_X_MSB    7
`define BSTSH_CMD_F1_BIT   8

// Operation codes held in the command register.
`define BSTSH_OP_NONE      3'h0
`define BSTSH_OP_SENSE     3'h1
`define BSTSH_OP_TOGGLE    3'h2
`define BSTSH_OP_SHL_IMM   3'h3
`define BSTSH_OP_SHR_IMM   3'h4
`define BSTSH_OP_SHL_DYN   3'h5
`define BSTSH_OP_SHR_DYN   3'h6

// Status register field positions.
`define BSTSH_ST_BUSY_BIT  0
`define BSTSH_ST_DLY_BIT   1
`define BSTSH_ST_FOUND_BIT 2
`define BSTSH_ST_POS_LSB   4
`define BSTSH_ST_POS_MSB   8

// Reset values and bus responses.
`define BSTSH_REG_RST      16'h0000
`define BSTSH_RESP_OKAY    2'h0
`define BSTSH_RESP_SLVERR  2'h2

// Bit-sense step when no bit matches, and full-width shift count.
`define BSTSH_NOFIND_STEP  5'h10
`define BSTSH_FULL_SHIFT   5'h10

`endif

// File: hw/bstsh_shifter.v
`timescale 1ns/1ps
`include "bstsh_defs.vh"

// Two-rank left shifter: rank one moves 0..3, rank two moves 0/4/8/12.
module bstsh_shifter #(
   parameter W = 32
) (
   input  wire [W-1:0] operand,
   input  wire [3:0]   rank1_sel,
   input  wire [3:0]   rank2_sel,
   input  wire         shift16,
   output wire [W-1:0] result
);

   wire [W-1:0] r1_0;
   wire [W-1:0] r1_1;
   wire [W-1:0] r1_2;
   wire [W-1:0] r1_3;
   wire [W-1:0] rank1;
   wire [W-1:0] r2_0;
   wire [W-1:0] r2_4;
   wire [W-1:0] r2_8;
   wire [W-1:0] r2_12;
   wire [W-1:0] rank2;

   ////////////////////////////////////////////////////////////////////////////
   // Candidate vectors; bits pushed off the top are lost, zeros enter below.
   assign r1_0  = operand;
   assign r1_1  = {operand[W-2:0], 1'b0};
   assign r1_2  = {operand[W-3:0], 2'b00};
   assign r1_3  = {operand[W-4:0], 3'b000};
   assign r2_0  = rank1;
   assign r2_4  = {rank1[W-5:0], 4'h0};
   assign r2_8  = {rank1[W-9:0], 8'h00};
   assign r2_12 = {rank1[W-13:0], 12'h000};

   ////////////////////////////////////////////////////////////////////////////
   // One selector per bit in each rank, enabled by one-hot count lines.
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_rank
         assign rank1[i] = (rank1_sel[0] & r1_0[i]) | (rank1_sel[1] & r1_1[i]) |
                           (rank1_sel[2] & r1_2[i]) | (rank1_sel[3] & r1_3[i]);
         assign rank2[i] = (rank2_sel[0] & r2_0[i]) | (rank2_sel[1] & r2_4[i]) |
                           (rank2_sel[2] & r2_8[i]) | (rank2_sel[3] & r2_12[i]);
      end
   endgenerate

   // A count of sixteen moves the low word wholly into the high word.
   assign result = shift16 ? {operand[W/2-1:0], {(W/2){1'b0}}} : rank2;

endmodule // bstsh_shifter

// File: hw/bstsh_unit.v
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`include "bstsh_defs.vh"

// Function
// - Bit sense scans A from position 00 up to 15 for requested value.
// - B grows by one per position passed, equal to found position.
// - Sense-and-toggle does a plain sense and also inverts the found bit.
// - Polarity select feeds A true when 0, complemented when 1.
// - Two eight-input priority encoders combine into a four-bit position.
// - The position is added to B in one addition.
// - Position splits into two decoded parts ANDed into a one-hot select.
// - Per-bit mux picks toggle select when toggle path is high, else shifter.
// - Fan-in enable gates shifter and sense path for shift and toggle.
// - Selected A bit flips like a JK flip-flop on the A clock enable.
// - Shifter shifts the 32-bit A:B operand left by the shift count.
// - Count from X field, or D bits 0-3, or instruction bits 4-7.
// - Left shifts use the count; right shifts use its two's complement.
// - First rank of 32 selectors shifts 0 to 3 by the low two count bits.
// - Second rank shifts 0, 4, 8 or 12; together up to 15 places.
// - At zero shift each B bit keeps its own position in the result.
// - Left result comes from one half, right result from the other half.
// - Bits shifted past the top are discarded, never wrapped.
// - Vacated low positions fill with zeros.
// - Shifts take two cycles; A and B load once the delay flop is set.
module bstsh_unit #(
   parameter AW = 8
) (
   input  wire          aclk,
   input  wire          aresetn,
   input  wire [AW-1:0] s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output wire          s_axi_awready,
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output wire          s_axi_wready,
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   input  wire [AW-1:0] s_axi_araddr,
   input  wire          s_axi_arvalid,
   output wire          s_axi_arready,
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready,
   output wire          block_microword_load,
   output wire          sequencer_address_clock_enable
);

   localparam ST_IDLE  = 3'b001;
   localparam ST_EXEC  = 3'b010;
   localparam ST_DELAY = 3'b100;

   reg  [15:0]   a_reg;
   reg  [15:0]   b_reg;
   reg  [15:0]   d_reg;
   reg  [15:0]   mi_reg;
   reg  [8:0]    cmd_reg;
   reg  [2:0]    state_reg;
   reg           found_reg;
   reg  [3:0]    pos_reg;
   reg           aw_have_reg;
   reg  [AW-1:0] aw_addr_reg;
   reg           w_have_reg;
   reg  [31:0]   w_data_reg;
   reg  [3:0]    w_strb_reg;
   reg  [15:0]   a_next;
   reg  [15:0]   b_next;
   reg  [2:0]    state_next;

   wire          wr_fire;
   wire          rd_fire;
   wire          busy;
   wire [2:0]    op;
   wire          is_sense;
   wire          is_toggle;
   wire          is_shift;
   wire          is_right;
   wire [15:0]   sense_in;
   wire [15:0]   sense_bus;
   wire [3:0]    enc_hi;
   wire [3:0]    enc_lo;
   wire          any_found;
   wire [3:0]    position;
   wire [4:0]    b_step;
   wire [3:0]    toggle_code_high_part;
   wire [3:0]    toggle_code_low_part;
   wire [15:0]   toggle_sel;
   wire [3:0]    raw_count;
   wire [4:0]    eff_count;
   wire [7:0]    shift_code;
   wire [31:0]   shift_out;
   wire [31:0]   fanin;
   wire          toggle_path_select;
   wire          shift_sense_fanin_enable;
   wire          a_reg_clock_enable;
   wire          b_reg_clock_enable;
   wire          right_shift_indicator;
   wire          sense_polarity_select;

   ////////////////////////////////////////////////////////////////////////////
   // Eight-input priority encoder for the first zero, position 0 leftmost.
   // Returns {found, position[2:0]}; vector bit 7 holds position 0.
   function [3:0] first_zero8;
      input [7:0] v;
      integer k;
      begin
         first_zero8 = 4'h0;
         for (k = 0; k < 8; k = k + 1) begin
            if (!v[k]) begin
               first_zero8 = {1'b1, 3'd7 - k[2:0]};
            end
         end
      end
   endfunction

   // Byte-lane merge of a write into a 16-bit register.
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] data;
      input [3:0]  strb;
      begin
         merge16 = old;
         if (strb[0]) begin
            merge16[7:0] = data[7:0];
         end
         if (strb[1]) begin
            merge16[15:8] = data[15:8];
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Write channel: address and data are captured independently.
   assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
   assign wr_fire       = aw_have_reg && w_have_reg && !s_axi_bvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg  <= 1'b0;
         aw_addr_reg  <= {AW{1'b0}};
         w_have_reg   <= 1'b0;
         w_data_reg   <= 32'h0000_0000;
         w_strb_reg   <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `BSTSH_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_have_reg  <= 1'b0;
            w_have_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr_reg[7:0] == `BSTSH_A_OFS || aw_addr_reg[7:0] == `BSTSH_B_OFS ||
                aw_addr_reg[7:0] == `BSTSH_D_OFS || aw_addr_reg[7:0] == `BSTSH_MI_OFS ||
                aw_addr_reg[7:0] == `BSTSH_CMD_OFS || aw_addr_reg[7:0] == `BSTSH_STAT_OFS) begin
               s_axi_bresp <= `BSTSH_RESP_OKAY;
            end else begin
               s_axi_bresp <= `BSTSH_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel: one cycle from address acceptance to data.
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_fire       = s_axi_arvalid && s_axi_arready;

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `BSTSH_RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `BSTSH_RESP_OKAY;
         if (s_axi_araddr[7:0] == `BSTSH_A_OFS) begin
            s_axi_rdata <= {16'h0000, a_reg};
         end else if (s_axi_araddr[7:0] == `BSTSH_B_OFS) begin
            s_axi_rdata <= {16'h0000, b_reg};
         end else if (s_axi_araddr[7:0] == `BSTSH_D_OFS) begin
            s_axi_rdata <= {16'h0000, d_reg};
         end else if (s_axi_araddr[7:0] == `BSTSH_MI_OFS) begin
            s_axi_rdata <= {16'h0000, mi_reg};
         end else if (s_axi_araddr[7:0] == `BSTSH_CMD_OFS) begin
            s_axi_rdata <= {23'h000000, cmd_reg};
         end else if (s_axi_araddr[7:0] == `BSTSH_STAT_OFS) begin
            s_axi_rdata <= {24'h000000, pos_reg, 1'b0, found_reg,
                            state_reg[2], busy};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `BSTSH_RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Operation decode from the latched command word.
   assign busy                  = !state_reg[0];
   assign op                    = cmd_reg[`BSTSH_CMD_OP_MSB:`BSTSH_CMD_OP_LSB];
   assign is_sense              = (op == `BSTSH_OP_SENSE) || (op == `BSTSH_OP_TOGGLE);
   assign is_toggle             = (op == `BSTSH_OP_TOGGLE);
   assign is_right              = (op == `BSTSH_OP_SHR_IMM) || (op == `BSTSH_OP_SHR_DYN);
   assign is_shift              = is_right || (op == `BSTSH_OP_SHL_IMM) ||
                                  (op == `BSTSH_OP_SHL_DYN);
   assign sense_polarity_select = cmd_reg[`BSTSH_CMD_POL_BIT];
   assign right_shift_indicator = is_right;
   assign toggle_path_select    = is_toggle;

   ////////////////////////////////////////////////////////////////////////////
   // Bit sense: precondition A, then find the first zero from position 00.
   assign sense_in  = sense_polarity_select ? ~a_reg : a_reg;
   assign enc_hi    = first_zero8(sense_in[15:8]);
   assign enc_lo    = first_zero8(sense_in[7:0]);
   assign sense_bus = sense_in;
   assign any_found = enc_hi[3] | enc_lo[3];
   // Positions 00-07 sit in the upper byte and win over 08-15.
   assign position  = enc_hi[3] ? {1'b0, enc_hi[2:0]} :
                                  {1'b1, enc_lo[2:0]};
   // One addition stands in for a step per position passed.
   assign b_step    = any_found ? {1'b0, position} : `BSTSH_NOFIND_STEP;

   ////////////////////////////////////////////////////////////////////////////
   // Toggle select: two decoded halves of the position ANDed per bit.
   genvar n;
   generate
      for (n = 0; n < 4; n = n + 1) begin : g_tdec
         assign toggle_code_high_part[n] = (position[3:2] == n);
         assign toggle_code_low_part[n]  = (position[1:0] == n);
      end
      for (n = 0; n < 16; n = n + 1) begin : g_tsel
         // Position p maps to vector bit 15-p, so position 00 is the MSB.
         assign toggle_sel[15-n] = any_found & toggle_code_high_part[n/4] &
                                   toggle_code_low_part[n%4];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Shift count source, direction conversion and one-hot rank code.
   assign raw_count = (op == `BSTSH_OP_SHL_DYN || op == `BSTSH_OP_SHR_DYN) ?
                      (cmd_reg[`BSTSH_CMD_F1_BIT] ? mi_reg[7:4] : d_reg[3:0]) :
                      cmd_reg[`BSTSH_CMD_X_MSB:`BSTSH_CMD_X_LSB];
   // Right shift becomes a left shift by sixteen minus the count.
   assign eff_count = right_shift_indicator ?
                      (`BSTSH_FULL_SHIFT - {1'b0, raw_count}) :
                      {1'b0, raw_count};
   generate
      for (n = 0; n < 4; n = n + 1) begin : g_code
         assign shift_code[4+n] = (eff_count[1:0] == n) & !eff_count[4];
         assign shift_code[n]   = (eff_count[3:2] == n) & !eff_count[4];
      end
   endgenerate

   // Operand is A in the high word and B in the low word.
   bstsh_shifter #(
      .W (32)
   ) u_shifter (
      .operand   ({a_reg, b_reg}),
      .rank1_sel (shift_code[7:4]),
      .rank2_sel (shift_code[3:0]),
      .shift16   (eff_count[4]),
      .result    (shift_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Fan-in: per-bit choice of toggle designator or shifter bit, then gate.
   assign shift_sense_fanin_enable = (is_shift || is_toggle) && busy;
   generate
      for (n = 0; n < 32; n = n + 1) begin : g_fanin
         if (n >= 16) begin : g_a
            assign fanin[n] = shift_sense_fanin_enable &
               (toggle_path_select ? toggle_sel[n-16] : shift_out[n]);
         end else begin : g_b
            assign fanin[n] = shift_sense_fanin_enable &
               (toggle_path_select ? 1'b0 : shift_out[n]);
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Clock enables: sense commits in its only cycle, shifts once delayed.
   assign a_reg_clock_enable = (state_reg == ST_EXEC && is_toggle) ||
                               state_reg == ST_DELAY;
   assign b_reg_clock_enable = (state_reg == ST_EXEC && is_sense) ||
                               state_reg == ST_DELAY;

   // First shift cycle holds off the next microword and sequencer address.
   assign block_microword_load           = (state_reg == ST_EXEC) && is_shift;
   assign sequencer_address_clock_enable = !block_microword_load;

   ////////////////////////////////////////////////////////////////////////////
   // Next values of A, B and the sequencing state.
   always @* begin
      a_next     = a_reg;
      b_next     = b_reg;
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (wr_fire && aw_addr_reg[7:0] == `BSTSH_CMD_OFS &&
                w_strb_reg[0]) begin
               state_next = ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (is_shift) begin
               state_next = ST_DELAY;
            end else begin
               state_next = ST_IDLE;
            end
            if (a_reg_clock_enable) begin
               a_next = a_reg ^ fanin[31:16];
            end
            if (b_reg_clock_enable) begin
               b_next = b_reg + {11'h000, b_step};
            end
         end
         ST_DELAY: begin
            // Both words load; left result in B, right result in A.
            a_next     = fanin[31:16];
            b_next     = fanin[15:0];
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register file and datapath registers; software writes are dropped while busy.
   always @(posedge aclk) begin
      if (!aresetn) begin
         a_reg     <= `BSTSH_REG_RST;
         b_reg     <= `BSTSH_REG_RST;
         d_reg     <= `BSTSH_REG_RST;
         mi_reg    <= `BSTSH_REG_RST;
         cmd_reg   <= 9'h000;
         state_reg <= ST_IDLE;
         found_reg <= 1'b0;
         pos_reg   <= 4'h0;
      end else begin
         state_reg <= state_next;
         a_reg     <= a_next;
         b_reg     <= b_next;
         if (state_reg == ST_EXEC && is_sense) begin
            found_reg <= any_found;
            pos_reg   <= any_found ? position : 4'h0;
         end
         if (wr_fire && !busy) begin
            if (aw_addr_reg[7:0] == `BSTSH_A_OFS) begin
               a_reg <= merge16(a_reg, w_data_reg, w_strb_reg);
            end else if (aw_addr_reg[7:0] == `BSTSH_B_OFS) begin
               b_reg <= merge16(b_reg, w_data_reg, w_strb_reg);
            end else if (aw_addr_reg[7:0] == `BSTSH_D_OFS) begin
               d_reg <= merge16(d_reg, w_data_reg, w_strb_reg);
            end else if (aw_addr_reg[7:0] == `BSTSH_MI_OFS) begin
               mi_reg <= merge16(mi_reg, w_data_reg, w_strb_reg);
            end else if (aw_addr_reg[7:0] == `BSTSH_CMD_OFS) begin
               if (w_strb_reg[0]) begin
                  cmd_reg[7:0] <= w_data_reg[7:0];
               end
               if (w_strb_reg[1]) begin
                  cmd_reg[8] <= w_data_reg[8];
               end
            end
         end
      end
   end

endmodule // bstsh_unit
